/* verilog/rla_rx_align_status.sv */
// Operation
// - Lane sync bit high only while word-synced and markers arrive as expected.
// - Sync-fail set on hunt failure, header errors after sync, or missing markers.
// - Sync-fail and interval-fault held until resync or another lane error.
// - Interval fault when markers arrive off the configured meta-frame spacing.
// - Repeat fault after four consecutive invalid markers, held like the others.
// - Invalid-marker pulse, one cycle per bad marker, only after word sync.
// - Aligned only when all lanes are aligned and deskewed.
// - Align error on repeated alignment failure or loss of aligned.
// - Skew pulse, one cycle, when markers do not land on all lanes together.
// - Per-lane four-bit header error count with a qualifier.
// - Per-position five-bit number naming the PCS lane shown there.
// - Lane-found bit set after sync once the lane is identified.
// - Per-lane block-lock bit follows sync-header lock.
// - Link status is aligned and not high error rate.
// - Local fault is internal fault or received fault, level.
// - CRC mismatch pulse, one cycle per bad packet.
// - Packet error flag on end-of-packet cycle unless CRC check bypassed.
// - Seven-bit count of cycles spent in the PCS error state.
// - Error status outputs update on the rising clock edge.
// - Markers recognised against twenty programmable values with standard defaults.
// - Sync and alignment outputs update on the rising clock edge.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module rla_rx_align_status (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register bus
    input wire rla_pkg::rla_axi_req_t axiReq,
    output rla_pkg::rla_axi_rsp_t axiRsp,
    // Lane blocks from the gearboxes
    input wire rla_pkg::rla_lane_t laneIn [rla_pkg::LANES],
    // Link quality and packet check inputs
    input wire logic high_error_rate,
    input wire logic internalFault,
    input wire logic receivedFault,
    input wire logic pcsErrorState,
    input wire logic crcCheckDone,
    input wire logic crcMatch,
    input wire logic packetEndIn,
    // Lane status
    output logic [19:0] lane_word_sync_ok,
    output logic [19:0] lane_word_sync_fail,
    output logic [19:0] marker_interval_fault,
    output logic [19:0] marker_repeat_fault,
    output logic [19:0] marker_invalid_pulse,
    output logic [19:0] lane_found,
    output logic [19:0] blockLock,
    output rla_pkg::rla_frame_err_t frameErr [rla_pkg::LANES],
    output logic [4:0] lane_position_id [rla_pkg::LANES],
    // Alignment and link status
    output logic aligned,
    output logic alignError,
    output logic marker_skew_pulse,
    output logic linkStatus,
    output logic localFault,
    // Packet error status
    output logic crc_mismatch_pulse,
    output logic packet_error_flag,
    output logic packet_end_flag,
    output logic [6:0] badCodeCount
);
    // Marker lookup: returns hit in bit 5 and lane index below
    function automatic logic [5:0] markerMatch(input logic [63:0] word, input logic [63:0] tbl [rla_pkg::LANES]);
        logic [5:0] res;
        res = 6'h00;
        for (int k = 0; k < rla_pkg::LANES; k++) begin
            if ((word & rla_pkg::MARKER_MASK) == (tbl[k] & rla_pkg::MARKER_MASK)) begin
                res = {1'b1, 5'(k)};
            end
        end
        return res;
    endfunction : markerMatch

    logic [63:0] lane_marker_value [rla_pkg::LANES];
    logic crc_check_bypass;
    logic [15:0] metaLen;
    logic [4:0] markSel;
    logic [31:0] markLo;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [19:0] markerHit;
    logic [2:0] alignTries;

    // Write side of the bus: address and data may land in either order
    wire awTake = axiReq.awvalid && axiRsp.awready;
    wire wTake = axiReq.wvalid && axiRsp.wready;
    wire doWrite = awHeld && wHeld && !axiRsp.bvalid;
    wire next_awHeld = (awHeld || awTake) && !doWrite;
    wire next_wHeld = (wHeld || wTake) && !doWrite;
    wire next_bvalid = doWrite || (axiRsp.bvalid && !axiReq.bready);
    wire wrKnown = awAddr inside {rla_pkg::REG_CTRL, rla_pkg::REG_META_LEN, rla_pkg::REG_MARK_SEL,
        rla_pkg::REG_MARK_LO, rla_pkg::REG_MARK_HI};
    wire arTake = axiReq.arvalid && axiRsp.arready;
    wire next_rvalid = arTake || (axiRsp.rvalid && !axiReq.rready);

    // Read data decode; status words show live lane and link state
    logic [31:0] rdMux;
    logic rdKnown;
    always_comb begin
        rdMux = 32'h0;
        rdKnown = 1'b1;
        unique case (axiReq.araddr)
            rla_pkg::REG_CTRL: rdMux = {31'h0, crc_check_bypass};
            rla_pkg::REG_META_LEN: rdMux = {16'h0, metaLen};
            rla_pkg::REG_MARK_SEL: rdMux = {27'h0, markSel};
            rla_pkg::REG_MARK_LO: rdMux = lane_marker_value[markSel][31:0];
            rla_pkg::REG_MARK_HI: rdMux = lane_marker_value[markSel][63:32];
            rla_pkg::REG_STATUS: rdMux = {27'h0, localFault, linkStatus, alignError, aligned, high_error_rate};
            rla_pkg::REG_SYNC: rdMux = {12'h0, lane_word_sync_ok};
            rla_pkg::REG_LOCK: rdMux = {12'h0, blockLock};
            default: rdKnown = 1'b0;
        endcase
    end

    // Bus handshake registers; ready flags come from flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h0;
            wData <= 32'h0;
            axiRsp <= '0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            if (awTake) awAddr <= axiReq.awaddr;
            if (wTake) wData <= axiReq.wdata;
            axiRsp.awready <= !next_awHeld && !next_bvalid;
            axiRsp.wready <= !next_wHeld && !next_bvalid;
            axiRsp.bvalid <= next_bvalid;
            if (doWrite) axiRsp.bresp <= wrKnown ? rla_pkg::RESP_OKAY : rla_pkg::RESP_DECERR;
            axiRsp.arready <= !next_rvalid;
            axiRsp.rvalid <= next_rvalid;
            if (arTake) begin
                axiRsp.rdata <= rdMux;
                axiRsp.rresp <= rdKnown ? rla_pkg::RESP_OKAY : rla_pkg::RESP_DECERR;
            end
        end
    end

    // Control registers; marker high word commits the 64-bit value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_check_bypass <= 1'b0;
            metaLen <= rla_pkg::META_LEN_RESET;
            markSel <= 5'h0;
            markLo <= 32'h0;
            lane_marker_value <= rla_pkg::MARKER_RESET;
        end else if (doWrite) begin
            if (awAddr == rla_pkg::REG_CTRL) crc_check_bypass <= wData[0];
            if (awAddr == rla_pkg::REG_META_LEN) metaLen <= wData[15:0];
            if (awAddr == rla_pkg::REG_MARK_SEL) markSel <= wData[4:0];
            if (awAddr == rla_pkg::REG_MARK_LO) markLo <= wData;
            if (awAddr == rla_pkg::REG_MARK_HI && markSel < 5'(rla_pkg::LANES)) begin
                lane_marker_value[markSel] <= {wData, markLo};
            end
        end
    end

    // Per-lane lock, word sync, marker checks and sticky errors
    for (genvar i = 0; i < rla_pkg::LANES; i++) begin : gLane
        logic [6:0] goodCnt;
        logic [5:0] badCnt;
        logic [5:0] winCnt;
        logic [15:0] blkCnt;
        logic [1:0] missCnt;
        logic [2:0] repCnt;
        logic [3:0] hdrErrs;
        wire [1:0] hdr = laneIn[i].blk[65:64];
        wire hdrOk = laneIn[i].valid && (hdr == rla_pkg::HDR_DATA || hdr == rla_pkg::HDR_CTRL);
        wire hdrBad = laneIn[i].valid && !hdrOk;
        wire [5:0] hit = markerMatch(laneIn[i].blk[63:0], lane_marker_value);
        wire isMarker = laneIn[i].valid && hdr == rla_pkg::HDR_CTRL && hit[5];
        wire due = laneIn[i].valid && blkCnt == metaLen;
        wire goodMark = isMarker && hit[4:0] == lane_position_id[i];
        wire huntFail = !blockLock[i] && hdrBad && badCnt == rla_pkg::HUNT_BAD;
        wire lockLost = blockLock[i] && hdrBad && badCnt[4:0] == rla_pkg::LOCKED_BAD - 5'h1;
        wire noMarker = blockLock[i] && !lane_word_sync_ok[i] && due && missCnt == rla_pkg::MISS_LIMIT - 2'h1;
        wire setFail = huntFail || lockLost || noMarker;
        wire setIntv = lane_word_sync_ok[i] && isMarker && !due;
        wire badMark = lane_word_sync_ok[i] && due && !goodMark;
        wire setRep = badMark && repCnt == rla_pkg::REPEAT_LIMIT - 3'h1;
        wire gainSync = blockLock[i] && !lockLost && !lane_word_sync_ok[i] && isMarker;
        wire anyErr = setFail || setIntv || setRep;
        assign markerHit[i] = lane_word_sync_ok[i] && goodMark && due;

        // Block lock: hunt for good headers, drop on too many bad in a window
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                goodCnt <= 7'h0;
                badCnt <= 6'h0;
                winCnt <= 6'h0;
                blockLock[i] <= 1'b0;
            end else if (!blockLock[i]) begin
                goodCnt <= hdrBad ? 7'h0 : goodCnt + 7'(hdrOk);
                badCnt <= huntFail ? 6'h0 : badCnt + 6'(hdrBad);
                winCnt <= 6'h0;
                blockLock[i] <= hdrOk && goodCnt == rla_pkg::LOCK_GOOD - 7'h1;
            end else if (laneIn[i].valid) begin
                winCnt <= winCnt + 6'h1;
                badCnt <= (winCnt == 6'h3f || lockLost) ? 6'h0 : badCnt + 6'(hdrBad);
                goodCnt <= 7'h0;
                blockLock[i] <= !lockLost;
            end
        end

        // Word sync and marker tracking; the block counter restarts on every marker taken
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                blkCnt <= 16'h0;
                missCnt <= 2'h0;
                repCnt <= 3'h0;
                lane_word_sync_ok[i] <= 1'b0;
                lane_found[i] <= 1'b0;
                lane_position_id[i] <= 5'h0;
                marker_invalid_pulse[i] <= 1'b0;
            end else begin
                if (gainSync || markerHit[i] || due) blkCnt <= 16'h0;
                else if (laneIn[i].valid) blkCnt <= blkCnt + 16'h1;
                // Miss count only runs while locked and unsynced, so a fresh loss gets the full limit
                missCnt <= (!blockLock[i] || lane_word_sync_ok[i] || gainSync || noMarker) ? 2'h0
                    : missCnt + 2'(due);
                repCnt <= (!lane_word_sync_ok[i] || goodMark || setRep) ? 3'h0 : repCnt + 3'(badMark);
                if (gainSync) lane_position_id[i] <= hit[4:0];
                lane_word_sync_ok[i] <= (lane_word_sync_ok[i] || gainSync) && !anyErr && blockLock[i]
                    && !lockLost;
                lane_found[i] <= (lane_found[i] || gainSync) && !anyErr && blockLock[i] && !lockLost;
                marker_invalid_pulse[i] <= badMark;
            end
        end

        // Sticky errors: a new error replaces the others, regaining sync clears all
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                lane_word_sync_fail[i] <= 1'b0;
                marker_interval_fault[i] <= 1'b0;
                marker_repeat_fault[i] <= 1'b0;
            end else if (anyErr) begin
                lane_word_sync_fail[i] <= setFail;
                marker_interval_fault[i] <= setIntv;
                marker_repeat_fault[i] <= setRep;
            end else if (gainSync) begin
                lane_word_sync_fail[i] <= 1'b0;
                marker_interval_fault[i] <= 1'b0;
                marker_repeat_fault[i] <= 1'b0;
            end
        end

        // Header error tally, reported and cleared at each expected marker slot
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                hdrErrs <= 4'h0;
                frameErr[i] <= '0;
            end else begin
                frameErr[i].valid <= due;
                if (due) frameErr[i].count <= hdrErrs + 4'(hdrBad);
                if (due) hdrErrs <= 4'h0;
                else if (hdrBad && hdrErrs != 4'hf) hdrErrs <= hdrErrs + 4'h1; // Saturates rather than wraps
            end
        end
    end

    // Alignment: markers on every synced lane in one cycle means deskewed
    wire allSync = &lane_word_sync_ok;
    wire anyHit = |markerHit;
    wire skew = anyHit && markerHit != lane_word_sync_ok;
    wire next_aligned = allSync && !skew && (aligned || &markerHit);
    wire tryFail = !aligned && skew && alignTries == rla_pkg::ALIGN_TRIES - 3'h1;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aligned <= 1'b0;
            alignError <= 1'b0;
            alignTries <= 3'h0;
            marker_skew_pulse <= 1'b0;
            linkStatus <= 1'b0;
        end else begin
            aligned <= next_aligned;
            marker_skew_pulse <= skew;
            alignTries <= (aligned || tryFail) ? 3'h0 : alignTries + 3'(skew);
            if ((aligned && !next_aligned) || tryFail) alignError <= 1'b1;
            else if (next_aligned) alignError <= 1'b0;
            linkStatus <= next_aligned && !high_error_rate;
        end
    end

    // Packet checks and fault reporting, all registered on the clock edge
    wire crcBad = crcCheckDone && !crcMatch;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            localFault <= 1'b0;
            crc_mismatch_pulse <= 1'b0;
            packet_error_flag <= 1'b0;
            packet_end_flag <= 1'b0;
            badCodeCount <= 7'h0;
        end else begin
            localFault <= internalFault || receivedFault;
            crc_mismatch_pulse <= crcBad;
            packet_end_flag <= packetEndIn;
            packet_error_flag <= packetEndIn && crcBad && !crc_check_bypass;
            if (pcsErrorState && badCodeCount != 7'h7f) badCodeCount <= badCodeCount + 7'h1;
        end
    end
endmodule : rla_rx_align_status

/* verilog/rla_pkg.sv */
package rla_pkg;
    localparam int LANES = 20;
    localparam logic [63:0] MARKER_MASK = 64'hffffff00_ffffff00;
    localparam logic [63:0] MARKER_RESET [LANES] = '{
        64'hc1682100_3e97de00, 64'h9d718e00_628e7100, 64'h594be800_a6b41700, 64'h4d957b00_b26a8400,
        64'hf5070900_0af8f600, 64'hdd14c200_22eb3d00, 64'h9a4a2600_65b5d900, 64'h7b456600_84ba9900,
        64'ha0247600_5fdb8900, 64'h68c9fb00_97360400, 64'hfd6c9900_02936600, 64'hb9915500_466eaa00,
        64'h5cb9b200_a3464d00, 64'h1af8bd00_e5074200, 64'h83c7ca00_7c383500, 64'h3536cd00_cac93200,
        64'hc4314c00_3bceb300, 64'hadd6b700_52294800, 64'h5f662a00_a099d500, 64'hc0f0e500_3f0f1a00};
    localparam logic [1:0] HDR_DATA = 2'h1;
    localparam logic [1:0] HDR_CTRL = 2'h2;
    localparam logic [6:0] LOCK_GOOD = 7'h40;
    localparam logic [5:0] HUNT_BAD = 6'h3f;
    localparam logic [4:0] LOCKED_BAD = 5'h10;
    localparam logic [1:0] MISS_LIMIT = 2'h2;
    localparam logic [2:0] REPEAT_LIMIT = 3'h4;
    localparam logic [2:0] ALIGN_TRIES = 3'h4;
    localparam logic [15:0] META_LEN_RESET = 16'h3fff;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_META_LEN = 8'h04;
    localparam logic [7:0] REG_MARK_SEL = 8'h08;
    localparam logic [7:0] REG_MARK_LO = 8'h0c;
    localparam logic [7:0] REG_MARK_HI = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SYNC = 8'h18;
    localparam logic [7:0] REG_LOCK = 8'h1c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic valid;
        logic [65:0] blk;
    } rla_lane_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } rla_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rla_axi_rsp_t;

    typedef struct packed {
        logic [3:0] count;
        logic valid;
    } rla_frame_err_t;
endpackage : rla_pkg

/* test/rla_rx_align_status_asserts.sv */
`timescale 1ns/1ps
module rla_rx_align_status_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Watched inputs
    input wire logic high_error_rate,
    input wire logic internalFault,
    input wire logic receivedFault,
    input wire logic pcsErrorState,
    input wire logic crcCheckDone,
    input wire logic crcMatch,
    // Watched outputs
    input wire logic [19:0] lane_word_sync_ok,
    input wire logic [19:0] lane_found,
    input wire logic aligned,
    input wire logic alignError,
    input wire logic linkStatus,
    input wire logic localFault,
    input wire logic crc_mismatch_pulse,
    input wire logic packet_error_flag,
    input wire logic packet_end_flag,
    input wire logic [6:0] badCodeCount
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_link_aligned: assert property (linkStatus |-> aligned)
        else $error("link up without alignment");
    a_link_high_ber: assert property (high_error_rate [*2] |=> !linkStatus)
        else $error("link up during high error rate");
    // Guarded by the past reset so the first edge after release stays quiet
    a_fault_level: assert property ($past(reset_n) |-> localFault == $past(internalFault || receivedFault))
        else $error("local fault level wrong");
    a_crc_pulse: assert property ($past(reset_n) |-> crc_mismatch_pulse == $past(crcCheckDone && !crcMatch))
        else $error("crc pulse wrong");
    a_err_on_end: assert property (packet_error_flag |-> packet_end_flag && crc_mismatch_pulse)
        else $error("error flag off the end cycle");
    a_code_count: assert property (
        $past(reset_n) |-> badCodeCount == $past(badCodeCount) + 7'($past(pcsErrorState) && $past(badCodeCount) != 7'h7f))
        else $error("bad code count step wrong");
    a_found_synced: assert property ((lane_found & ~lane_word_sync_ok) == 20'h00000)
        else $error("lane found without sync");
    a_rise_all_sync: assert property ($rose(aligned) |-> &lane_word_sync_ok)
        else $error("aligned with a lane unsynced");
    a_fall_error: assert property ($fell(aligned) |-> ##[0:2] alignError)
        else $error("alignment loss not flagged");

    c_aligned: cover property ($rose(aligned));
    c_err_flag: cover property (packet_error_flag);
    c_ber_down: cover property (high_error_rate && aligned && !linkStatus);
endmodule : rla_rx_align_status_asserts

bind rla_rx_align_status rla_rx_align_status_asserts chk_u (.clk, .reset_n, .high_error_rate, .internalFault,
    .receivedFault, .pcsErrorState, .crcCheckDone, .crcMatch, .lane_word_sync_ok, .lane_found, .aligned,
    .alignError, .linkStatus, .localFault, .crc_mismatch_pulse, .packet_error_flag, .packet_end_flag, .badCodeCount);

/* test/rla_lane_tx.sv */
`timescale 1ns/1ps
module rla_lane_tx (
    // Clock
    input wire logic clk,
    // Bench controls
    input wire logic run,
    input wire logic [15:0] gap,
    input wire logic [19:0] corrupt,
    input wire logic [19:0] late,
    // Blocks toward the receiver
    output rla_pkg::rla_lane_t lanes [rla_pkg::LANES]
);
    logic [15:0] cnt = 16'h0000;
    logic tgl = 1'b0;

    // One shared slot counter keeps all lanes deskewed unless told otherwise
    always @(posedge clk) begin
        tgl <= ~tgl;
        if (run)
            cnt <= (cnt >= gap) ? 16'h0000 : cnt + 16'h0001;
    end

    // Data blocks keep the compared marker bytes zero, so they never alias a marker
    always_comb begin
        for (int i = 0; i < rla_pkg::LANES; i++) begin
            lanes[i].valid = run;
            lanes[i].blk = {rla_pkg::HDR_DATA, 48'h0, cnt};
            if (late[i] ? cnt == 16'h0000 : cnt == gap)
                lanes[i].blk = {rla_pkg::HDR_CTRL, rla_pkg::MARKER_RESET[i] ^ {55'h0, corrupt[i], 8'h00}};
            if (!run)
                lanes[i].blk = {66{tgl}}; // Idle line toggles so a stale block never looks fresh
        end
    end
endmodule : rla_lane_tx

/* test/rla_rx_align_status_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module rla_rx_align_status_tb_top;
    localparam logic [1:0] OK = rla_pkg::RESP_OKAY;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hber = 1'b0, intF = 1'b0, rcvF = 1'b0, pcsE = 1'b0, crcDone = 1'b0, crcOk = 1'b0, pEnd = 1'b0, run = 1'b0;
    logic [19:0] corrupt = 20'h0, late = 20'h0;
    logic [19:0] syncOk, syncFail, ivlF, rptF, invP, found, lock;
    logic aligned, alignErr, skewP, linkOk, locF, crcP, errF, endF;
    logic [6:0] badCode;
    logic [4:0] posId [rla_pkg::LANES];
    rla_pkg::rla_frame_err_t frameErr [rla_pkg::LANES];
    rla_pkg::rla_lane_t laneIn [rla_pkg::LANES];
    rla_pkg::rla_axi_req_t axiReq = '0;
    rla_pkg::rla_axi_rsp_t axiRsp;
    int n_errors = 0, tests_run = 0, invCnt = 0, skewCnt = 0;

    // Clock and pulse tallies
    always #2 clk = ~clk;
    always @(posedge clk) invCnt <= invCnt + int'(invP[3]);
    always @(posedge clk) skewCnt <= skewCnt + int'(skewP);

    rla_rx_align_status dut_u (.clk, .reset_n, .axiReq, .axiRsp, .laneIn, .high_error_rate(hber),
        .internalFault(intF), .receivedFault(rcvF), .pcsErrorState(pcsE), .crcCheckDone(crcDone),
        .crcMatch(crcOk), .packetEndIn(pEnd), .lane_word_sync_ok(syncOk), .lane_word_sync_fail(syncFail),
        .marker_interval_fault(ivlF), .marker_repeat_fault(rptF), .marker_invalid_pulse(invP),
        .lane_found(found), .blockLock(lock), .frameErr, .lane_position_id(posId), .aligned,
        .alignError(alignErr), .marker_skew_pulse(skewP), .linkStatus(linkOk), .localFault(locF),
        .crc_mismatch_pulse(crcP), .packet_error_flag(errF), .packet_end_flag(endF), .badCodeCount(badCode));
    rla_lane_tx lane_u (.clk, .run, .gap(16'h000f), .corrupt, .late, .lanes(laneIn));

    // Bus write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        @(posedge clk);
        axiReq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1, default: '0};
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1 && t < 100);
        axiReq.bready <= 1'b0;
        `CHK("bresp", er, axiRsp.bresp)
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int t;
        @(posedge clk);
        axiReq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        t = 0;
        do begin
            @(posedge clk);
            t++;
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1 && t < 100);
        axiReq.rready <= 1'b0;
        `CHK("rdata", ed, axiRsp.rdata)
        `CHK("rresp", er, axiRsp.rresp)
    endtask : rdc

    // Returns at the edge where the partner slot counter leaves 1, so a window of 16 holds one slot
    task automatic lap();
        while (lane_u.cnt !== 16'h0001) @(negedge clk);
        @(posedge clk);
    endtask : lap

    task automatic t_regs();
        rdc(rla_pkg::REG_CTRL, 32'h0, OK);
        rdc(rla_pkg::REG_META_LEN, 32'h3fff, OK);
        rdc(8'h40, 32'h0, rla_pkg::RESP_DECERR);
        wr(8'h40, 32'h1, rla_pkg::RESP_DECERR);
        wr(rla_pkg::REG_META_LEN, 32'hf, OK);
        rdc(rla_pkg::REG_META_LEN, 32'hf, OK);
        wr(rla_pkg::REG_MARK_SEL, 32'h3, OK);
        rdc(rla_pkg::REG_MARK_HI, rla_pkg::MARKER_RESET[3][63:32], OK);
        $display("regs done");
    endtask : t_regs

    task automatic t_align();
        int t;
        run <= 1'b1;
        for (t = 0; t < 600 && aligned !== 1'b1; t++) @(negedge clk);
        `CHK("aligned", 1'b1, aligned)
        `CHK("sync", 20'hfffff, syncOk)
        `CHK("found", 20'hfffff, found)
        `CHK("lock", 20'hfffff, lock)
        `CHK("link", 1'b1, linkOk)
        for (int i = 0; i < 20; i++) `CHK("pos", 5'(i), posId[i])
        for (t = 0; t < 40 && frameErr[0].valid !== 1'b1; t++) @(negedge clk);
        `CHK("frameErr", 5'h01, frameErr[0])
        rdc(rla_pkg::REG_STATUS, 32'ha, OK);
        hber <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK("link", 1'b0, linkOk)
        rdc(rla_pkg::REG_STATUS, 32'h3, OK);
        hber <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK("link", 1'b1, linkOk)
        $display("align done");
    endtask : t_align

    task automatic t_marker();
        int c;
        c = invCnt;
        lap();
        corrupt <= 20'h8;
        repeat (16) @(posedge clk);
        corrupt <= 20'h0;
        repeat (3) @(negedge clk);
        `CHK("invalid", c + 1, invCnt)
        lap();
        corrupt <= 20'h8;
        repeat (64) @(posedge clk);
        repeat (2) @(negedge clk);
        `CHK("repeat", 1'b1, rptF[3])
        `CHK("sync3", 1'b0, syncOk[3])
        `CHK("alignErr", 1'b1, alignErr)
        lap();
        repeat (48) @(posedge clk);
        corrupt <= 20'h0;
        repeat (2) @(negedge clk);
        `CHK("syncFail", 1'b1, syncFail[3])
        `CHK("repeat", 1'b0, rptF[3])
        repeat (40) @(negedge clk);
        `CHK("syncFail", 1'b0, syncFail[3])
        `CHK("aligned", 1'b1, aligned)
        $display("marker done");
    endtask : t_marker

    task automatic t_late();
        int c;
        c = skewCnt;
        lap();
        late <= 20'h20;
        repeat (16) @(posedge clk);
        late <= 20'h0;
        repeat (2) @(negedge clk);
        `CHK("interval", 1'b1, ivlF[5])
        `CHK("sync5", 1'b0, syncOk[5])
        `CHK("skew", 1'b1, skewCnt > c)
        repeat (40) @(negedge clk);
        `CHK("interval", 1'b0, ivlF[5])
        $display("late done");
    endtask : t_late

    // Mismatch with check on, mismatch with bypass, then a good packet
    task automatic t_packet();
        for (int b = 0; b < 3; b++) begin
            wr(rla_pkg::REG_CTRL, 32'(b & 1), OK);
            pEnd <= 1'b1;
            crcDone <= 1'b1;
            crcOk <= (b == 2);
            @(posedge clk);
            pEnd <= 1'b0;
            crcDone <= 1'b0;
            @(negedge clk);
            `CHK("crc", b != 2, crcP)
            `CHK("errFlag", b == 0, errF)
            `CHK("endFlag", 1'b1, endF)
            @(negedge clk);
            `CHK("crc", 1'b0, crcP)
        end
        $display("packet done");
    endtask : t_packet

    task automatic t_fault();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            intF <= k[0];
            rcvF <= k[1];
            @(posedge clk);
            @(negedge clk);
            `CHK("fault", k != 0, locF)
        end
        @(posedge clk);
        pcsE <= 1'b1;
        repeat (10) @(posedge clk);
        pcsE <= 1'b0;
        @(negedge clk);
        `CHK("badCode", 7'h0a, badCode)
        $display("fault done");
    endtask : t_fault

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (7) @(posedge clk);
        @(negedge clk);
        `CHK("sync", 20'h0, syncOk)
        `CHK("aligned", 1'b0, aligned)
        @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_align();
        t_marker();
        t_late();
        t_packet();
        t_fault();
        wrap_up();
    end

    // Whole run is about five hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        $display("[ERR] watchdog expired");
        n_errors++;
        wrap_up();
    end
endmodule : rla_rx_align_status_tb_top
